/* core/pidc_bcd2bin.sv */
// Four-digit BCD to binary converter, one instance per gain
`timescale 1ns/10ps
module pidc_bcd2bin (
	input wire logic [15:0] bcd, // Four BCD digits
	output logic [13:0] bin // Binary value 0..9999
);
	// Weighted digit sum; digits above nine are not guarded
	always_comb begin
		bin = 14'(bcd[15:12]) * 14'd1000 + 14'(bcd[11:8]) * 14'd100
			+ 14'(bcd[7:4]) * 14'd10 + 14'(bcd[3:0]);
	end
endmodule

/* core/pidc_core.sv */
// Loop calculation core with Avalon-MM loop table
// Summary of operation
// (RULE1) Enabled setpoint limiting clamps setpoint to limits
// (RULE2) Output clamped to limits; zero upper caps
// (RULE3) Each result written to output word five
// (RULE4) Gains kept as four-digit BCD hundredths
// (RULE5) Output sums P, I, D on one error
// (RULE6) Zero proportional gain drops proportional term
// (RULE7) Integral gain 0000 or 9999 drops integrator
// (RULE8) Integral unit seconds or minutes scales term
// (RULE9) Zero derivative gain drops term; else seconds
// (RULE10) Optional derivative limit configurable zero to twenty
// (RULE11) Error recomputed each pass as setpoint minus PV
// (RULE12) Squaring replaces error, sign kept
// (RULE13) Deadband zeroes small errors, passes large ones
// (RULE14) Without freeze, bias accumulates to its limit
// (RULE15) Freeze stops bias at output range ends
// (RULE16) Freeze uses full data range, not limits
// (RULE17) Software sets mode bit ten for freeze
// (RULE18) Runs once per sample period, 50 ms upward
// (RULE19) Bipolar values are magnitude plus sign
// (RULE20) Manual mode: no calculation, no output write
// (RULE21) BCD gains converted to binary hundredths
`timescale 1ns/10ps
`include "pidc_defs.svh"
module pidc_core import pidc_pkg::*; #(
	parameter int TICK_CYCLES = `PIDC_TICK_MS * `PIDC_CLK_MHZ * 1000,
	parameter int DATA_MAX = 4095 // Full data range end
) (
	input wire logic clk, // 250 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [5:0] avs_address, // Word address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	output logic calc_done // Pulse after each calculation
);
	localparam logic [15:0] DMAX = 16'(DATA_MAX);
	localparam logic [15:0] MAG_MASK = 16'h7fff;

	// Loop table storage
	logic [15:0] table_q [16]; // Sixteen loop table words
	logic ack_q; // Bus answer pending
	logic [31:0] rdata_q; // Registered read data
	pidc_state_t state_q; // Sequencer state
	logic [31:0] tick_q; // Cycles within one 10 ms tick
	logic [15:0] ticks_q; // Ticks since last calculation
	logic signed [31:0] err_q; // Shaped error
	logic signed [31:0] prev_err_q; // Error of previous pass
	logic signed [31:0] bias_q; // Integral bias accumulator
	logic signed [31:0] pterm_q; // Proportional term
	logic signed [31:0] dterm_q; // Derivative term
	logic signed [31:0] out_q; // Sum clamped to output limits
	logic out_wr_q; // Calculation writes output word
	logic [15:0] out_word_q; // Coded result
	logic done_q; // Completion pulse
	pidc_gains_t gains; // Converted gains

	wire logic [15:0] mode1 = table_q[`PIDC_IDX_MODE1];
	wire logic bipolar = mode1[`PIDC_BIT_BIPOLAR];
	wire logic auto_mode = mode1[`PIDC_BIT_AUTO];

	// Gain conversion, one converter per gain
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_gain
			logic [13:0] b;
			pidc_bcd2bin u_cv (
				.bcd(table_q[`PIDC_IDX_GAIN_P + 4'(gi)]),
				.bin(b)
			); // [RULE4] [RULE21]
		end
	endgenerate
	// One driver for the whole carrier, fields in declared order
	assign gains = {g_gain[0].b, g_gain[1].b, g_gain[2].b};

	// Decode a table word into a signed value
	function automatic logic signed [31:0] dec(input logic [15:0] w,
		input logic bip);
		logic signed [31:0] m;
		m = signed'({16'h0000, w & MAG_MASK});
		if (!bip) begin
			dec = signed'({16'h0000, w});
		end else if (w[15]) begin
			dec = -m; // [RULE19]
		end else begin
			dec = m;
		end
	endfunction

	// Encode a signed value as magnitude plus sign
	function automatic logic [15:0] enc(input logic signed [31:0] v,
		input logic bip);
		logic [31:0] a;
		a = v < 0 ? 32'(-v) : 32'(v);
		if (bip && v < 0) begin
			enc = {1'b1, a[14:0]}; // [RULE19]
		end else begin
			enc = a[15:0];
		end
	endfunction

	// Clamp between two bounds
	function automatic logic signed [31:0] clamp(
		input logic signed [31:0] v, input logic signed [31:0] lo,
		input logic signed [31:0] hi);
		if (v > hi) begin
			clamp = hi;
		end else if (v < lo) begin
			clamp = lo;
		end else begin
			clamp = v;
		end
	endfunction

	// Setpoint with optional limiting
	logic signed [31:0] sp_eff;
	always_comb begin
		sp_eff = dec(table_q[`PIDC_IDX_SETPOINT], bipolar);
		if (mode1[`PIDC_BIT_SPLIM]) begin
			sp_eff = clamp(sp_eff, dec(table_q[`PIDC_IDX_SP_LO], bipolar),
				dec(table_q[`PIDC_IDX_SP_HI], bipolar)); // [RULE1]
		end
	end

	// Bus slave: one wait cycle then answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata = rdata_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// Read data; addresses above fifteen read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			rdata_q <= avs_address[5:4] == 2'b00 ?
				{16'h0000, table_q[avs_address[3:0]]} : 32'h0000_0000;
		end
	end

	// Table writes; calculation owns output word except in manual
	wire logic bus_wr = avs_write & ack_q & (avs_address[5:4] == 2'b00);
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				table_q[i] <= 16'h0000;
			end
			table_q[`PIDC_IDX_MODE1] <= `PIDC_RST_MODE1;
			table_q[`PIDC_IDX_OUT_HI] <= `PIDC_RST_OUT_HI;
			table_q[`PIDC_IDX_SAMPLE] <= `PIDC_RST_SAMPLE;
		end else begin
			if (bus_wr) begin
				table_q[avs_address[3:0]] <= avs_writedata[15:0];
			end
			if (out_wr_q) begin
				table_q[`PIDC_IDX_OUT] <= out_word_q; // [RULE3]
			end
		end
	end

	// Sample period timer in 10 ms ticks
	wire logic [15:0] period = table_q[`PIDC_IDX_SAMPLE] < `PIDC_MIN_SAMPLE
		? `PIDC_MIN_SAMPLE : table_q[`PIDC_IDX_SAMPLE];
	wire logic tick = tick_q == 32'(TICK_CYCLES - 1);
	wire logic due = tick && ticks_q + 16'h0001 >= period;
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q <= 32'h0000_0000;
			ticks_q <= 16'h0000;
		end else begin
			tick_q <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
			if (due) begin
				ticks_q <= 16'h0000; // [RULE18]
			end else if (tick) begin
				ticks_q <= ticks_q + 16'h0001;
			end
		end
	end

	// Error shaping helpers
	logic signed [31:0] raw_err;
	logic signed [31:0] shaped;
	logic [31:0] mag;
	always_comb begin
		raw_err = sp_eff - dec(table_q[`PIDC_IDX_PROCVAR], bipolar);
		shaped = raw_err; // [RULE11]
		mag = raw_err < 0 ? 32'(-raw_err) : 32'(raw_err);
		if (mode1[`PIDC_BIT_SQUARE]) begin
			// Square scaled back to data range so big errors stay sane
			mag = 32'((64'(mag) * 64'(mag)) / 64'(DMAX + 16'h0001));
			shaped = raw_err < 0 ? -signed'(mag) : signed'(mag); // [RULE12]
		end
		if (mode1[`PIDC_BIT_DBAND] &&
			mag <= 32'(table_q[`PIDC_IDX_DBAND])) begin
			shaped = 32'sh0; // [RULE13]
		end
	end

	// Derivative limit value, held at most twenty
	wire logic [15:0] dlim = table_q[`PIDC_IDX_DLIM] > `PIDC_DLIM_MAX ?
		`PIDC_DLIM_MAX : table_q[`PIDC_IDX_DLIM];
	logic signed [31:0] dlim_bound;
	assign dlim_bound = signed'(32'(dlim)) * signed'(32'(DMAX)); // [RULE10]

	// Integral increment for this pass
	logic signed [31:0] i_inc;
	wire logic ki_off = table_q[`PIDC_IDX_GAIN_I] == 16'h0000 ||
		table_q[`PIDC_IDX_GAIN_I] == `PIDC_BCD_MAX;
	always_comb begin
		// Increment is error times period over integral time
		i_inc = ki_off ? 32'sh0 : (err_q * signed'(32'(period)))
			/ signed'(32'(gains.ki)); // [RULE7]
		if (mode1[`PIDC_BIT_MINUTES]) begin
			i_inc = i_inc / 32'sd60; // [RULE8]
		end
	end

	// Output at full data range end triggers freeze
	wire logic signed [31:0] range_hi = signed'(32'(DMAX));
	wire logic signed [31:0] range_lo = bipolar ? -range_hi : 32'sh0;
	wire logic at_end = out_q >= range_hi || out_q <= range_lo;

	// Calculation sequencer; idle while in manual
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= PIDC_IDLE;
		end else begin
			case (state_q)
				PIDC_IDLE: begin
					if (due && auto_mode) begin
						state_q <= PIDC_ERR; // [RULE20]
					end
				end
				PIDC_ERR: state_q <= PIDC_SHAPE;
				PIDC_SHAPE: state_q <= PIDC_TERMS;
				PIDC_TERMS: state_q <= PIDC_SUM;
				PIDC_SUM: state_q <= PIDC_WRITE;
				PIDC_WRITE: state_q <= PIDC_IDLE;
				default: state_q <= PIDC_IDLE;
			endcase
		end
	end

	// Datapath registers updated per state
	always_ff @(posedge clk) begin
		if (rst) begin
			err_q <= 32'sh0;
			prev_err_q <= 32'sh0;
			bias_q <= 32'sh0;
			pterm_q <= 32'sh0;
			dterm_q <= 32'sh0;
			out_q <= 32'sh0;
		end else begin
			case (state_q)
				PIDC_ERR: err_q <= shaped; // one error for all terms [RULE5]
				PIDC_TERMS: begin
					// Gains are hundredths, hence the division
					pterm_q <= gains.kp == 14'd0 ? 32'sh0 :
						(err_q * signed'(32'(gains.kp))) / 32'sd100; // [RULE6]
					dterm_q <= gains.kd == 14'd0 ? 32'sh0 :
						clamp(((err_q - prev_err_q) *
						signed'(32'(gains.kd))) / 32'sd100,
						mode1[`PIDC_BIT_DLIMEN] ? -dlim_bound : -32'sh7fffffff,
						mode1[`PIDC_BIT_DLIMEN] ? dlim_bound : 32'sh7fffffff);
						// [RULE9] [RULE10]
					prev_err_q <= err_q;
					// Freeze only at full range end, not at limits [RULE16]
					if (!(mode1[`PIDC_BIT_FREEZE] && at_end)) begin // [RULE15]
						bias_q <= clamp(bias_q + i_inc, range_lo,
							range_hi); // [RULE14]
					end
				end
				PIDC_SUM: out_q <= clamp(pterm_q + bias_q + dterm_q,
					dec(table_q[`PIDC_IDX_OUT_LO], bipolar),
					dec(table_q[`PIDC_IDX_OUT_HI], bipolar)); // [RULE2] [RULE5]
				default: begin
				end
			endcase
		end
	end

	// Output word write strobe and completion pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			out_wr_q <= 1'b0;
			out_word_q <= 16'h0000;
			done_q <= 1'b0;
		end else begin
			out_wr_q <= state_q == PIDC_WRITE && auto_mode; // [RULE3] [RULE20]
			out_word_q <= enc(out_q, bipolar);
			done_q <= state_q == PIDC_WRITE;
		end
	end
	assign calc_done = done_q;

	// Checks
	property p_out_hi;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_SUM |=> out_q <=
			$past(dec(table_q[`PIDC_IDX_OUT_HI], bipolar));
	endproperty
	a_out_hi: assert property (p_out_hi) else $error("output above limit"); // [RULE2]

	property p_write;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_WRITE && auto_mode |=> ##1
			table_q[`PIDC_IDX_OUT] == $past(out_word_q);
	endproperty
	a_write: assert property (p_write) else $error("output word not written"); // [RULE3]

	property p_manual;
		@(posedge clk) disable iff (rst)
		!auto_mode && state_q == PIDC_IDLE |=> state_q == PIDC_IDLE;
	endproperty
	a_manual: assert property (p_manual) else $error("ran in manual"); // [RULE20]

	property p_freeze;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_TERMS && mode1[`PIDC_BIT_FREEZE] && at_end
			|=> $stable(bias_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("bias moved frozen"); // [RULE15]

	property p_pzero;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_TERMS && gains.kp == 14'd0 |=> pterm_q == 32'sh0;
	endproperty
	a_pzero: assert property (p_pzero) else $error("P term not removed"); // [RULE6]

	property p_dzero;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_TERMS && gains.kd == 14'd0 |=> dterm_q == 32'sh0;
	endproperty
	a_dzero: assert property (p_dzero) else $error("D term not removed"); // [RULE9]

	property p_izero;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_TERMS && ki_off && !at_end |=> $stable(bias_q);
	endproperty
	a_izero: assert property (p_izero) else $error("I term not removed"); // [RULE7]

	sequence s_run;
		state_q == PIDC_ERR ##1 state_q == PIDC_SHAPE;
	endsequence
	property p_seq;
		@(posedge clk) disable iff (rst)
		s_run |=> state_q == PIDC_TERMS ##1 state_q == PIDC_SUM
			##1 state_q == PIDC_WRITE;
	endproperty
	a_seq: assert property (p_seq) else $error("sequence broken"); // [RULE5]

	property p_dlim;
		@(posedge clk) disable iff (rst)
		state_q == PIDC_TERMS && mode1[`PIDC_BIT_DLIMEN] |=>
			dterm_q <= $past(dlim_bound) && dterm_q >= -$past(dlim_bound);
	endproperty
	a_dlim: assert property (p_dlim) else $error("D term over limit"); // [RULE10]
endmodule

/* inc/pidc_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PIDC_DEFS_SVH
`define PIDC_DEFS_SVH
// Loop table word indexes; byte address is four times the index
`define PIDC_IDX_MODE1 4'h0
`define PIDC_IDX_OUT 4'h5
// Registers of our own placement
`define PIDC_IDX_SETPOINT 4'h2
`define PIDC_IDX_PROCVAR 4'h3
`define PIDC_IDX_GAIN_P 4'h8
`define PIDC_IDX_GAIN_I 4'h9
`define PIDC_IDX_GAIN_D 4'ha
`define PIDC_IDX_SAMPLE 4'hb
`define PIDC_IDX_SP_HI 4'hc
`define PIDC_IDX_SP_LO 4'hd
`define PIDC_IDX_OUT_HI 4'he
`define PIDC_IDX_OUT_LO 4'hf
`define PIDC_IDX_DBAND 4'h1
`define PIDC_IDX_DLIM 4'h4
`define PIDC_IDX_BIAS 4'h6
// Mode word one bit positions
`define PIDC_BIT_AUTO 0
`define PIDC_BIT_BIPOLAR 1
`define PIDC_BIT_SPLIM 2
`define PIDC_BIT_MINUTES 4
`define PIDC_BIT_SQUARE 5
`define PIDC_BIT_DBAND 6
`define PIDC_BIT_DLIMEN 7
`define PIDC_BIT_FREEZE 10
// Reset values
`define PIDC_RST_MODE1 16'h0000
`define PIDC_RST_OUT_HI 16'h0fff
`define PIDC_RST_SAMPLE 16'h0005
// Sample period unit is 10 ms; shortest period is 50 ms
`define PIDC_TICK_MS 10
`define PIDC_MIN_SAMPLE 16'h0005
`define PIDC_CLK_MHZ 250
`define PIDC_BCD_MAX 16'h9999
`define PIDC_DLIM_MAX 16'h0014
`endif

/* inc/pidc_pkg.sv */
// Types shared by the loop calculation core
package pidc_pkg;
	// Calculation sequencer states
	typedef enum logic [2:0] {
		PIDC_IDLE,
		PIDC_ERR,
		PIDC_SHAPE,
		PIDC_TERMS,
		PIDC_SUM,
		PIDC_WRITE
	} pidc_state_t;
	// Three gains as binary hundredths
	typedef struct packed {
		logic [13:0] kp;
		logic [13:0] ki;
		logic [13:0] kd;
	} pidc_gains_t;
endpackage

/* testbench/tb_pidc_core.sv */
// Self-checking testbench for the loop calculation core
`timescale 1ns/10ps
`include "pidc_defs.svh"
module tb_pidc_core;
	import pidc_pkg::*;
	logic clk = 1'b0; // Bench clock
	logic rst = 1'b1; // Synchronous reset
	logic [5:0] avs_address = 6'h00; // Word address
	logic avs_read = 1'b0; // Read strobe
	logic avs_write = 1'b0; // Write strobe
	logic [31:0] avs_writedata = 32'h0; // Write data
	logic [31:0] avs_readdata; // Read data
	logic avs_waitrequest; // Stall
	logic calc_done; // Calculation pulse
	int mismatches = 0; // Failed comparisons
	int n_compared = 0; // All comparisons
	logic [15:0] rd; // Scratch read value
	logic [15:0] o1, o2, o3, o4; // Integrator samples

	// Short tick keeps each sample period at a few dozen cycles
	pidc_core #(.TICK_CYCLES(10), .DATA_MAX(4095)) u_dut (
		.clk(clk), // Clock
		.rst(rst), // Reset
		.avs_address(avs_address), // Address
		.avs_read(avs_read), // Read
		.avs_write(avs_write), // Write
		.avs_writedata(avs_writedata), // Write data
		.avs_readdata(avs_readdata), // Read data
		.avs_waitrequest(avs_waitrequest), // Stall
		.calc_done(calc_done) // Done pulse
	);

	// 250 MHz clock
	always #2 clk = ~clk;

	// Word index to bus address
	function automatic logic [5:0] ix(input logic [3:0] i);
		return {2'b00, i};
	endfunction

	// Ends the run with one verdict
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Word comparison
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Held request; waitrequest sampled at rising edges only
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 100) chk("waitrequest", 16'h0, 16'h1);
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdw(input logic [5:0] a, output logic [15:0] q);
		bus(1'b0, a, 16'h0, q);
	endtask

	// Waits for the next completion pulse, returns cycles taken
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (calc_done !== 1'b1 && n < 2000);
		if (n >= 2000) chk("calc_done", 16'h1, 16'h0);
	endtask

	// Loads a loop, lets one full pass use it, reads the output word
	task automatic run_loop(input logic [15:0] sp, input logic [15:0] pv,
		input logic [15:0] kp, input logic [15:0] ki, input logic [15:0] md,
		output logic [15:0] q);
		int n;
		wr(ix(`PIDC_IDX_SETPOINT), sp);
		wr(ix(`PIDC_IDX_PROCVAR), pv);
		wr(ix(`PIDC_IDX_GAIN_P), kp);
		wr(ix(`PIDC_IDX_GAIN_I), ki);
		wr(ix(`PIDC_IDX_MODE1), md);
		wait_done(n);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), q);
	endtask

	// Reset values, unmapped place, BCD and limit words
	task automatic t_regs();
		rdw(ix(`PIDC_IDX_MODE1), rd);
		chk("mode1", `PIDC_RST_MODE1, rd);
		rdw(ix(`PIDC_IDX_OUT_HI), rd);
		chk("out_hi", `PIDC_RST_OUT_HI, rd);
		rdw(ix(`PIDC_IDX_SAMPLE), rd);
		chk("sample", `PIDC_RST_SAMPLE, rd);
		wr(6'h20, 16'h5a5a);
		rdw(6'h20, rd);
		chk("unmapped", 16'h0000, rd);
		wr(ix(`PIDC_IDX_GAIN_P), 16'h1234);
		rdw(ix(`PIDC_IDX_GAIN_P), rd);
		chk("kp_bcd", 16'h1234, rd);
		wr(ix(`PIDC_IDX_DLIM), 16'h001e);
		rdw(ix(`PIDC_IDX_DLIM), rd);
		chk("d_limit", 16'h001e, rd);
	endtask

	// Manual mode leaves the output word to the bus writer
	task automatic t_manual();
		int seen;
		seen = 0;
		wr(ix(`PIDC_IDX_OUT), 16'h0123);
		repeat (200) begin
			@(posedge clk);
			if (calc_done === 1'b1) seen++;
		end
		chk("manual_done", 16'h0, 16'(seen));
		rdw(ix(`PIDC_IDX_OUT), rd);
		chk("manual_out", 16'h0123, rd);
	endtask

	// Pass spacing follows the sample word
	task automatic t_period();
		int n;
		wr(ix(`PIDC_IDX_SAMPLE), 16'h0006);
		wr(ix(`PIDC_IDX_MODE1), 16'h0001);
		wait_done(n);
		wait_done(n);
		wait_done(n);
		chk("period", 16'h003c, 16'(n));
		wr(ix(`PIDC_IDX_SAMPLE), 16'h0005);
	endtask

	// Gains, shaping, limits on error 1000 - 400 = 600
	task automatic t_calc();
		run_loop(16'd1000, 16'd400, 16'h0100, 16'h0000, 16'h0001, rd);
		chk("p_only", 16'd600, rd);
		run_loop(16'd1000, 16'd400, 16'h0000, 16'h9999, 16'h0001, rd);
		chk("p_zero", 16'd0, rd);
		run_loop(16'd1000, 16'd400, 16'h9999, 16'h0000, 16'h0001, rd);
		chk("out_clamp", 16'h0fff, rd);
		wr(ix(`PIDC_IDX_OUT_HI), 16'h0100);
		run_loop(16'd1000, 16'd400, 16'h9999, 16'h0000, 16'h0001, rd);
		chk("out_hi_lim", 16'h0100, rd);
		wr(ix(`PIDC_IDX_OUT_HI), 16'h0000);
		run_loop(16'd1000, 16'd400, 16'h9999, 16'h0000, 16'h0001, rd);
		chk("out_hi_zero", 16'h0000, rd);
		wr(ix(`PIDC_IDX_OUT_HI), 16'h0fff);
		wr(ix(`PIDC_IDX_SP_HI), 16'd500);
		wr(ix(`PIDC_IDX_SP_LO), 16'd0);
		run_loop(16'd1000, 16'd400, 16'h0100, 16'h0000, 16'h0005, rd);
		chk("sp_limit", 16'd100, rd);
		// Squared error is 600*600/4096, truncated
		run_loop(16'd1000, 16'd400, 16'h0100, 16'h0000, 16'h0021, rd);
		chk("err_square", 16'd87, rd);
		wr(ix(`PIDC_IDX_DBAND), 16'd700);
		run_loop(16'd1000, 16'd400, 16'h0100, 16'h0000, 16'h0041, rd);
		chk("dband_in", 16'd0, rd);
		wr(ix(`PIDC_IDX_DBAND), 16'd500);
		run_loop(16'd1000, 16'd400, 16'h0100, 16'h0000, 16'h0041, rd);
		chk("dband_out", 16'd600, rd);
	endtask

	// Integrator runs on; minutes step slower than seconds
	task automatic t_integral();
		int n;
		run_loop(16'd1000, 16'd400, 16'h0000, 16'h0100, 16'h0001, o1);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), o2);
		chk("bias_grows", 16'h1, 16'(o2 > o1));
		// Error 600 over 0.05 s at 1.00 s integral time adds 30 per pass
		chk("i_step", 16'd30, o2 - o1);
		run_loop(16'd1000, 16'd400, 16'h0000, 16'h0100, 16'h0011, o3);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), o4);
		chk("minutes", 16'h1, 16'((o4 - o3) < (o2 - o1)));
	endtask

	// Bias holds while the output sits at the top of the data range
	task automatic t_freeze();
		int n;
		wr(ix(`PIDC_IDX_GAIN_I), 16'h9999);
		wr(ix(`PIDC_IDX_GAIN_P), 16'h0000);
		wait_done(n);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), o1);
		wr(ix(`PIDC_IDX_GAIN_P), 16'h9999);
		wait_done(n);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), rd);
		chk("freeze_sat", 16'h0fff, rd);
		wr(ix(`PIDC_IDX_MODE1), 16'h0401);
		wr(ix(`PIDC_IDX_GAIN_I), 16'h0100);
		wait_done(n);
		wait_done(n);
		// Integrator off before the output leaves the range end
		wr(ix(`PIDC_IDX_GAIN_I), 16'h9999);
		wr(ix(`PIDC_IDX_GAIN_P), 16'h0000);
		wait_done(n);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), rd);
		chk("bias_frozen", o1, rd);
	endtask

	// Derivative step, its limit, then a negative bipolar output
	task automatic t_deriv();
		int n;
		// Manual first, so the step lands on one whole pass
		wr(ix(`PIDC_IDX_MODE1), 16'h0000);
		wr(ix(`PIDC_IDX_GAIN_D), 16'h0100);
		wr(ix(`PIDC_IDX_PROCVAR), 16'd300);
		wr(ix(`PIDC_IDX_MODE1), 16'h0001);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), rd);
		chk("d_step", o1 + 16'd100, rd);
		wr(ix(`PIDC_IDX_MODE1), 16'h0000);
		wr(ix(`PIDC_IDX_DLIM), 16'h0000);
		wr(ix(`PIDC_IDX_PROCVAR), 16'd200);
		wr(ix(`PIDC_IDX_MODE1), 16'h0081);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), rd);
		chk("d_limited", o1, rd);
		wr(ix(`PIDC_IDX_MODE1), 16'h0000);
		wr(ix(`PIDC_IDX_GAIN_D), 16'h0000);
		wr(ix(`PIDC_IDX_GAIN_P), 16'h0100);
		wr(ix(`PIDC_IDX_OUT_LO), 16'h8fff);
		wr(ix(`PIDC_IDX_PROCVAR), 16'd1600);
		wr(ix(`PIDC_IDX_MODE1), 16'h0003);
		wait_done(n);
		rdw(ix(`PIDC_IDX_OUT), rd);
		// Error -600 plus the held bias, as magnitude and sign
		chk("bipolar", o1 < 16'd600 ? 16'h8000 | (16'd600 - o1)
			: o1 - 16'd600, rd);
	endtask

	// Watchdog against a hang
	initial begin
		#40000;
		mismatches++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_manual();
		t_period();
		t_calc();
		t_integral();
		t_freeze();
		t_deriv();
		close_out();
	end
endmodule
